// File: sdp_pkg.sv
// Shared constants and carrier types for the synchronous dual-port RAM
`default_nettype none

package sdp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Array geometry
    localparam int DATA_W     = 9;
    localparam int ADDR_W_MAX = 14;
    localparam int ADDR_W_DEF = 14;
    localparam int NUM_PORTS  = 2;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_MHZ                     = 20;
    localparam int CROSS_PORT_WRITE_READ_DELAY_NS = 40;
    localparam int CROSS_PORT_CLOCK_SKEW_NS    = 15;
    localparam int FLOW_CLOCK_TO_DATA_TIME_NS  = 20;
    // Longest time: round down, never below one cycle
    localparam int XP_WR_RD_CYC_RAW = (CROSS_PORT_WRITE_READ_DELAY_NS * CLK_MHZ) / 1000;
    localparam int XP_WR_RD_CYC     = (XP_WR_RD_CYC_RAW < 1) ? 1 : XP_WR_RD_CYC_RAW;

    ////////////////////////////////////////////////////////////////////////
    // Counter
    localparam logic [ADDR_W_MAX-1:0] CNT_CLEAR_ADDR = 14'h0000;
    localparam logic [ADDR_W_MAX-1:0] CNT_RESET_VAL  = 14'h0000;

    typedef enum logic [1:0] {
        SDP_CNT_HOLD  = 2'h0,
        SDP_CNT_INC   = 2'h1,
        SDP_CNT_LOAD  = 2'h3,
        SDP_CNT_CLEAR = 2'h2
    } sdp_cnt_op_t;

    ////////////////////////////////////////////////////////////////////////
    // Port carriers
    typedef struct packed {
        logic                  select_active_low_b;
        logic                  select_active_high;
        logic                  read_not_write;
        logic                  address_load_strobe_b;
        logic                  counter_advance_enable_b;
        logic                  counter_clear_b;
        logic                  output_enable_b;
        logic                  output_latency_select;
        logic [ADDR_W_MAX-1:0] addr;
        logic [DATA_W-1:0]     data;
    } sdp_port_in_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              data_oe;
    } sdp_port_out_t;

endpackage

`default_nettype wire

// File: sdp_burst_ctr.sv
// Per-port burst address counter with clear, load, hold and increment
`default_nettype none

module sdp_burst_ctr #(
    parameter int ADDR_BITS = sdp_pkg::ADDR_W_DEF
) (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_rst_b,
    input  wire logic [ADDR_BITS-1:0]    i_ext_addr,
    input  wire logic                    i_load_b,
    input  wire logic                    i_adv_b,
    input  wire logic                    i_clr_b,
    output var  logic [ADDR_BITS-1:0]    o_int_addr,
    output var  sdp_pkg::sdp_cnt_op_t    o_op
);
    import sdp_pkg::*;

    typedef struct packed {
        logic [ADDR_BITS-1:0] cnt;
    } sdp_ctr_state_t;

    sdp_ctr_state_t st_q;
    sdp_ctr_state_t st_d;

    initial begin
        if (ADDR_BITS < 1 || ADDR_BITS > ADDR_W_MAX) begin
            $error("ADDR_BITS out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operation decode, clear first; chip selects play no part
    always_comb begin
        st_d = st_q;
        if (!i_clr_b) begin
            o_op = SDP_CNT_CLEAR;
        end else if (!i_load_b) begin
            o_op = SDP_CNT_LOAD;
        end else if (!i_adv_b) begin
            o_op = SDP_CNT_INC;
        end else begin
            o_op = SDP_CNT_HOLD;
        end
        unique case (o_op)
            SDP_CNT_CLEAR: st_d.cnt = CNT_CLEAR_ADDR[ADDR_BITS-1:0];
            SDP_CNT_LOAD:  st_d.cnt = i_ext_addr;
            SDP_CNT_INC:   st_d.cnt = st_q.cnt + 1'b1;
            SDP_CNT_HOLD:  st_d.cnt = st_q.cnt;
        endcase
        // Access goes to the address the counter is moving to
        o_int_addr = st_d.cnt;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);

    ctr_clear_a: assert property (!i_clr_b |=> st_q.cnt == '0)
        else $error("counter not cleared");
    ctr_hold_a: assert property (i_clr_b && i_load_b && i_adv_b |=> $stable(st_q.cnt))
        else $error("counter moved while held");
    ctr_inc_a: assert property (i_clr_b && i_load_b && !i_adv_b
        |=> st_q.cnt == $past(st_q.cnt) + 1'b1)
        else $error("counter did not step by one");
    ctr_wrap_a: assert property (i_clr_b && i_load_b && !i_adv_b && (&st_q.cnt)
        |=> st_q.cnt == '0)
        else $error("counter did not wrap to zero");

endmodule

`default_nettype wire

// File: sdp_dual_ram.sv
// Synchronous dual-port RAM: array, per-port decode, output staging
`default_nettype none

module sdp_dual_ram #(
    parameter int ADDR_BITS = sdp_pkg::ADDR_W_DEF
) (
    input  wire logic                              i_sys_clk,
    input  wire logic                              i_rst_b,
    input  wire sdp_pkg::sdp_port_in_t  [1:0]      i_port,
    output var  sdp_pkg::sdp_port_out_t [1:0]      o_port
);
    import sdp_pkg::*;

    localparam int DEPTH = 1 << ADDR_BITS;

    initial begin
        if (ADDR_BITS < 1 || ADDR_BITS > ADDR_W_MAX) begin
            $error("ADDR_BITS out of range");
        end
        if (XP_WR_RD_CYC != 1) begin
            $error("array timing serves a one-cycle cross-port delay only");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [1:0][DATA_W-1:0] stage_data;
        logic [1:0]             stage_drive;
        logic [1:0][DATA_W-1:0] out_data;
        logic [1:0]             out_drive;
    } sdp_state_t;

    sdp_state_t st_q;
    sdp_state_t st_d;

    logic [DATA_W-1:0]    mem_q [DEPTH];

    logic [1:0]           selected;
    logic [1:0]           rd_op;
    logic [1:0]           wr_op;
    logic [1:0]           pipelined;
    logic [ADDR_BITS-1:0] int_addr [2];
    logic [DATA_W-1:0]    rd_word  [2];
    sdp_cnt_op_t          cnt_op   [2];

    ////////////////////////////////////////////////////////////////////////
    // Per-port decode and burst counter
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        sdp_burst_ctr #(
            .ADDR_BITS (ADDR_BITS)
        ) u_ctr (
            .i_sys_clk  (i_sys_clk),
            .i_rst_b    (i_rst_b),
            .i_ext_addr (i_port[p].addr[ADDR_BITS-1:0]),
            .i_load_b   (i_port[p].address_load_strobe_b),
            .i_adv_b    (i_port[p].counter_advance_enable_b),
            .i_clr_b    (i_port[p].counter_clear_b),
            .o_int_addr (int_addr[p]),
            .o_op       (cnt_op[p])
        );

        // Both selects must agree for any access
        assign selected[p]  = !i_port[p].select_active_low_b
                              && i_port[p].select_active_high;
        assign rd_op[p]     = selected[p] && i_port[p].read_not_write;
        assign wr_op[p]     = selected[p] && !i_port[p].read_not_write;
        assign pipelined[p] = i_port[p].output_latency_select;

        // Array read sees the word as it stood before this edge
        assign rd_word[p]   = mem_q[int_addr[p]];

        // Pin drive gated by the asynchronous output enable
        assign o_port[p].data    = st_q.out_data[p];
        assign o_port[p].data_oe = st_q.out_drive[p]
                                   && !i_port[p].output_enable_b;
    end

    ////////////////////////////////////////////////////////////////////////
    // Array write; port 1 lands last on a same-word collision
    always_ff @(posedge i_sys_clk) begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (wr_op[p]) begin
                mem_q[int_addr[p]] <= i_port[p].data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output staging: flow path loads this edge, pipelined path one later
    always_comb begin
        st_d = st_q;
        for (int p = 0; p < NUM_PORTS; p++) begin
            st_d.stage_data[p]  = rd_op[p] ? rd_word[p] : st_q.stage_data[p];
            st_d.stage_drive[p] = rd_op[p];
            if (pipelined[p]) begin
                st_d.out_data[p]  = st_q.stage_data[p];
                st_d.out_drive[p] = st_q.stage_drive[p];
            end else begin
                st_d.out_data[p]  = st_d.stage_data[p];
                st_d.out_drive[p] = rd_op[p];
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_chk
        localparam int Q = 1 - p;

        sequence flow_read_s;
            rd_op[p] && !pipelined[p];
        endsequence

        sequence pipe_read_s;
            rd_op[p] && pipelined[p] ##1 pipelined[p];
        endsequence

        sequence flow_deselect_s;
            !selected[p] && !pipelined[p];
        endsequence

        sequence pipe_deselect_s;
            !selected[p] && pipelined[p] ##1 pipelined[p];
        endsequence

        sequence lone_write_s;
            wr_op[p] && !(wr_op[Q] && int_addr[Q] == int_addr[p]);
        endsequence

        sequence cross_read_s;
            wr_op[p] && !wr_op[Q]
            ##1 rd_op[Q] && !pipelined[Q] && int_addr[Q] == $past(int_addr[p]);
        endsequence

        desel_flow_a: assert property (flow_deselect_s |=> !st_q.out_drive[p])
            else $error("flow outputs not floated after deselect");

        desel_pipe_a: assert property (pipe_deselect_s |=> !st_q.out_drive[p])
            else $error("pipelined outputs not floated a cycle later");

        read_flow_a: assert property (flow_read_s
            |=> st_q.out_drive[p] && st_q.out_data[p] == $past(rd_word[p]))
            else $error("flow read data or drive wrong");

        read_pipe_a: assert property (pipe_read_s
            |=> st_q.out_drive[p] && st_q.out_data[p] == $past(rd_word[p], 2))
            else $error("pipelined read not one cycle later");

        write_store_a: assert property (lone_write_s
            |=> mem_q[$past(int_addr[p])] == $past(i_port[p].data))
            else $error("write data not stored");

        write_float_a: assert property (wr_op[p] && !pipelined[p]
            |=> !st_q.out_drive[p])
            else $error("outputs driven during write");

        oe_async_a: assert property (i_port[p].output_enable_b
            |-> !o_port[p].data_oe)
            else $error("outputs driven while output enable high");

        addr_ext_a: assert property (!i_port[p].address_load_strobe_b
            && i_port[p].counter_clear_b
            |-> int_addr[p] == i_port[p].addr[ADDR_BITS-1:0])
            else $error("external address not used on load");

        addr_clear_a: assert property (!i_port[p].counter_clear_b
            |-> int_addr[p] == '0 && cnt_op[p] == SDP_CNT_CLEAR)
            else $error("clear cycle did not access address zero");

        cross_port_a: assert property (cross_read_s
            |=> st_q.out_data[Q] == $past(i_port[p].data, 2))
            else $error("cross-port read missed the earlier write");

        // Counter operation as seen at the pins
        logic do_load;
        logic do_hold;
        logic do_step;
        logic do_clear;

        assign do_clear = !i_port[p].counter_clear_b;
        assign do_load  = !do_clear && !i_port[p].address_load_strobe_b;
        assign do_hold  = !do_clear && i_port[p].address_load_strobe_b
                          && i_port[p].counter_advance_enable_b;
        assign do_step  = !do_clear && i_port[p].address_load_strobe_b
                          && !i_port[p].counter_advance_enable_b;

        sequence reselect_s;
            !selected[p] ##1 rd_op[p] && pipelined[p];
        endsequence

        sequence pipe_release_s;
            rd_op[p] && pipelined[p] ##1 !selected[p] && pipelined[p];
        endsequence

        ctr_free_a: assert property (i_port[p].counter_clear_b
            ##1 !selected[p] && do_step
            |-> int_addr[p] == $past(int_addr[p]) + 1'b1)
            else $error("counter step blocked by deselect");

        // Counter load, hold, step and clear
        load_every_a: assert property (do_load ##1 do_hold
            |-> int_addr[p] == $past(i_port[p].addr[ADDR_BITS-1:0]))
            else $error("loaded address not kept");

        load_step_a: assert property (do_load ##1 do_step
            |-> int_addr[p] == $past(i_port[p].addr[ADDR_BITS-1:0]) + 1'b1)
            else $error("step after load from wrong base");

        load_op_a: assert property (do_load
            |-> cnt_op[p] == SDP_CNT_LOAD)
            else $error("load not decoded");

        hold_addr_a: assert property (do_hold ##1 do_hold
            |-> int_addr[p] == $past(int_addr[p]))
            else $error("held counter moved");

        hold_op_a: assert property (do_hold
            |-> cnt_op[p] == SDP_CNT_HOLD)
            else $error("hold not decoded");

        step_addr_a: assert property (do_step ##1 do_step
            |-> int_addr[p] == $past(int_addr[p]) + 1'b1)
            else $error("burst step not by one");

        step_op_a: assert property (do_step
            |-> cnt_op[p] == SDP_CNT_INC)
            else $error("step not decoded");

        clear_hold_a: assert property (do_clear ##1 do_hold
            |-> int_addr[p] == '0)
            else $error("cleared counter not held at zero");

        clear_wins_a: assert property (do_clear && !i_port[p].address_load_strobe_b
            |-> int_addr[p] == '0)
            else $error("load beat the clear");

        clear_step_a: assert property (do_clear ##1 do_step
            |-> int_addr[p] == ADDR_BITS'(1))
            else $error("step after clear not at one");

        clear_read_a: assert property (do_clear && rd_op[p] && !pipelined[p]
            |=> st_q.out_drive[p])
            else $error("read lost in clear cycle");

        // Output timing per latency mode
        resel_pipe_a: assert property (reselect_s
            |=> !st_q.out_drive[p])
            else $error("pipelined reselect drove too early");

        pipe_release_a: assert property (pipe_release_s
            |=> st_q.out_drive[p])
            else $error("pipelined deselect floated too early");

        desel_data_a: assert property (!pipelined[p]
            ##1 !selected[p] && !pipelined[p]
            |=> $stable(st_q.out_data[p]))
            else $error("data changed while deselected");

        flow_idle_a: assert property (!pipelined[p] && !rd_op[p]
            |=> !st_q.out_drive[p])
            else $error("flow outputs driven without read");

        latency_pipe_a: assert property (rd_op[p] && pipelined[p]
            && !st_q.stage_drive[p]
            |=> !st_q.out_drive[p])
            else $error("pipelined read skipped its stage");

        latency_flow_a: assert property (rd_op[p] && !pipelined[p]
            |=> st_q.out_data[p] == st_q.stage_data[p])
            else $error("flow read not bypassing the stage");

        pipe_old_a: assert property (rd_op[p] && pipelined[p]
            |=> st_q.out_data[p] == $past(st_q.stage_data[p]))
            else $error("pipelined output not from the stage");

        oe_follow_a: assert property (!i_port[p].output_enable_b
            |-> o_port[p].data_oe == st_q.out_drive[p])
            else $error("pin drive not following registered drive");

        // Staging register and select decode
        write_keep_a: assert property (wr_op[p]
            |=> $stable(st_q.stage_data[p]))
            else $error("write disturbed read stage");

        read_stage_a: assert property (rd_op[p]
            |=> st_q.stage_drive[p] && st_q.stage_data[p] == $past(rd_word[p]))
            else $error("read stage not loaded");

        idle_stage_a: assert property (!rd_op[p]
            |=> !st_q.stage_drive[p])
            else $error("stage drive set without read");

        sel_both_a: assert property (i_port[p].select_active_low_b
            || !i_port[p].select_active_high
            |-> !rd_op[p] && !wr_op[p])
            else $error("access taken while deselected");
    end

endmodule

`default_nettype wire

// File: sdp_host_model.sv
// Host-side bus model for one RAM port
`default_nettype none

module sdp_host_model
    import sdp_pkg::*;
(
    input  wire sdp_pkg::sdp_port_in_t i_peer,
    output var  sdp_pkg::sdp_port_in_t o_port
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [DATA_W-1:0] last_q;

    initial begin
        o_port = '1;
        last_q = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Called by the bench at time zero and just after falling edges
    task automatic put(input sdp_port_in_t c);
        sdp_port_in_t v;
        v = c;
        if (!c.read_not_write && !i_peer.read_not_write && c.addr == i_peer.addr &&
            !c.select_active_low_b && !i_peer.select_active_low_b) begin
            v.select_active_low_b = 1'b1;
        end
        if (c.read_not_write || v.select_active_low_b) begin
            v.data = ~last_q;
        end else begin
            // Kept so read and no-operation cycles drive its complement on the data lines
            last_q = c.data;
        end
        o_port = v;
    endtask

endmodule

`default_nettype wire

// File: testbench.sv
// Self-checking bench for the dual-port RAM
`default_nettype none

`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end

module testbench;
    import sdp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic              port;
        logic              rnw;
        logic              pipe;
        logic [13:0]       addr;
        logic [DATA_W-1:0] d;
    } sdp_tb_row_t;

    logic                i_sys_clk   = 1'b0;
    logic                i_rst_b     = 1'b0;
    int                  n_mismatch  = 0;
    int                  check_count = 0;
    sdp_port_in_t        p0;
    sdp_port_in_t        p1;
    sdp_port_in_t        c;
    sdp_port_in_t        idle;
    sdp_port_out_t [1:0] out;
    sdp_port_out_t       o;
    sdp_tb_row_t         rows [6];

    always #25 i_sys_clk = ~i_sys_clk;

    sdp_host_model host_u (
        .i_peer (p0),
        .o_port (p1)
    );

    sdp_dual_ram #(.ADDR_BITS(14)) dut_u (
        .i_sys_clk (i_sys_clk),
        .i_rst_b   (i_rst_b),
        .i_port    ({p1, p0}),
        .o_port    (out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic sdp_port_in_t mk(input logic sel, rnw, ads_b, adv_b, clr_b, pipe,
                                        input logic [13:0] a, input logic [8:0] d);
        mk = {~sel, 1'b1, rnw, ads_b, adv_b, clr_b, 1'b0, pipe, a, d};
    endfunction

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One port-0 cycle, checked after the taking edge
    task automatic cs(input sdp_port_in_t cmd, input logic eoe, input logic [8:0] ed);
        p0 = cmd;
        @(negedge i_sys_clk);
        `CHK("oe0", eoe, out[0].data_oe)
        if (eoe) `CHK("data0", ed, out[0].data)
    endtask

    initial begin
        repeat (2000) @(posedge i_sys_clk);
        n_mismatch++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rows[0] = {1'b0, 1'b0, 1'b0, 14'h0005, 9'h1A5};
        rows[1] = {1'b1, 1'b1, 1'b0, 14'h0005, 9'h1A5};
        rows[2] = {1'b1, 1'b0, 1'b0, 14'h3FFF, 9'h0C3};
        rows[3] = {1'b0, 1'b1, 1'b1, 14'h3FFF, 9'h0C3};
        rows[4] = {1'b1, 1'b1, 1'b1, 14'h0005, 9'h1A5};
        rows[5] = {1'b0, 1'b1, 1'b0, 14'h3FFF, 9'h0C3};
        idle = mk(0, 1, 1, 1, 1, 0, 14'h0000, 9'h0AA);
        p0 = idle;
        host_u.put(idle);
        repeat (4) @(negedge i_sys_clk);
        `CHK("rst_oe", 2'b00, {out[1].data_oe, out[0].data_oe})
        `CHK("rst_data", 18'h00000, {out[1].data, out[0].data})
        i_rst_b = 1'b1;
        @(negedge i_sys_clk);
        foreach (rows[i]) begin
            c = mk(1, rows[i].rnw, 0, 1, 1, rows[i].pipe, rows[i].addr,
                   rows[i].rnw ? 9'h155 : rows[i].d);
            if (rows[i].port) host_u.put(c);
            else p0 = c;
            repeat (rows[i].pipe ? 2 : 1) @(negedge i_sys_clk);
            o = out[rows[i].port];
            `CHK("row_oe", rows[i].rnw, o.data_oe)
            if (rows[i].rnw) `CHK("row_data", rows[i].d, o.data)
            if (rows[i].port) host_u.put(idle);
            else p0 = idle;
            @(negedge i_sys_clk);
        end
        // Output enable gates the pins without a clock edge
        p0 = mk(1, 1, 0, 1, 1, 0, 14'h0005, 9'h155);
        @(negedge i_sys_clk);
        #5 p0.output_enable_b = 1'b1;
        #1 `CHK("oe_async", 1'b0, out[0].data_oe)
        p0.output_enable_b = 1'b0;
        #1 `CHK("oe_back", 1'b1, out[0].data_oe)
        // Pipelined deselect lags by one cycle
        @(negedge i_sys_clk);
        p0 = mk(1, 1, 0, 1, 1, 1, 14'h0005, 9'h0AA);
        repeat (2) @(negedge i_sys_clk);
        `CHK("pipe_data", 9'h1A5, out[0].data)
        cs(mk(0, 1, 0, 1, 1, 1, 14'h0005, 9'h155), 1'b1, 9'h1A5);
        cs(mk(0, 1, 0, 1, 1, 1, 14'h0005, 9'h155), 1'b0, 9'h000);
        // Burst counter: load, increment with wrap, clear, hold
        cs(mk(1, 0, 0, 1, 1, 0, 14'h3FFE, 9'h101), 1'b0, 9'h000);
        cs(mk(1, 0, 1, 0, 1, 0, 14'h0000, 9'h102), 1'b0, 9'h000);
        cs(mk(1, 0, 1, 0, 1, 0, 14'h1234, 9'h103), 1'b0, 9'h000);
        cs(mk(1, 1, 0, 1, 0, 0, 14'h0005, 9'h0AA), 1'b1, 9'h103);
        cs(mk(1, 1, 1, 1, 1, 0, 14'h3FFE, 9'h155), 1'b1, 9'h103);
        cs(mk(1, 1, 0, 1, 1, 0, 14'h3FFE, 9'h0AA), 1'b1, 9'h101);
        cs(mk(1, 1, 1, 0, 1, 0, 14'h0005, 9'h155), 1'b1, 9'h102);
        cs(mk(0, 1, 1, 0, 1, 0, 14'h0005, 9'h0AA), 1'b0, 9'h000);
        cs(mk(1, 1, 1, 1, 1, 0, 14'h2222, 9'h155), 1'b1, 9'h103);
        close_out();
    end

endmodule

`undef CHK

`default_nettype wire
